// File: verilog/data_ram_addressing_stack.sv
`timescale 1ns/100ps
module data_ram_addressing_stack
   import ram_addr_pkg::*;
#(
   parameter variant_t VARIANT = VAR_SMALL    // Device variant
)(
   input  wire logic             clk,          // 10 MHz core clock
   input  wire logic             arst_n,       // Async reset, active low
   input  wire logic             ce,           // Clock enable
   input  wire req_t             req,          // Command from datapath
   output logic      [DIG_W-1:0] rdata,        // Digit swapped out of RAM
   output logic                  skip,         // Step skip flag
   output logic      [COL_W-1:0] strobe_out,   // Nibble strobe port
   output ram_ptr_t              ptr_out,      // Current pointer
   output logic      [PC_W-1:0]  ret_out,      // Popped return address
   output logic                  ret_valid     // Pop done pulse
);

   //------------------------------------------------------------
   // Reset release
   //------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n_reg;

   // Two-stage release of reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   //------------------------------------------------------------
   // Variant geometry
   //------------------------------------------------------------
   localparam logic SMALL = (VARIANT == VAR_SMALL);
   localparam logic HAS_STK = !SMALL;
   localparam int   SLOTS   = (VARIANT == VAR_BIG) ? 2 * SLOTS_ROW : SLOTS_ROW;

   // Stack bottom row for a given CPU
   function automatic logic [ROW_W-1:0] stack_base(input logic sel);
      case (VARIANT)
         VAR_ROW8:  stack_base = STK_ROW_A;
         VAR_DUAL:  stack_base = sel ? STK_ROW_B : STK_ROW_A;
         VAR_ROW15: stack_base = STK_ROW_HI;
         VAR_BIG:   stack_base = STK_ROW_BIG;
         default:   stack_base = STK_ROW_A;
      endcase
   endfunction

   // Cell address of a user pointer
   function automatic logic [ADDR_W-1:0] cell_of(input ram_ptr_t p);
      if (SMALL) begin
         // Top index bit dropped: two index values per cell
         cell_of = {p.row_index & (SMALL_ROWS - 5'h01), 1'b0,
                    p.column_index[COL_W-2:0]};
      end else begin
         cell_of = {p.row_index, p.column_index};
      end
   endfunction

   //------------------------------------------------------------
   // Pointer and strobe port
   //------------------------------------------------------------
   ram_ptr_t         ptr_reg;
   logic [COL_W-1:0] col_next;

   // Full four-bit step, wraps 15->0 and 0->15
   always_comb begin
      col_next = ptr_reg.column_index;
      if (req.cmd == CMD_STEP_UP) begin
         col_next = ptr_reg.column_index + 4'h1;
      end else if (req.cmd == CMD_STEP_DOWN) begin
         col_next = ptr_reg.column_index - 4'h1;
      end
   end

   // Pointer register, full width index kept
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ptr_reg <= '{row_index: ROW_ZERO, column_index: COL_ZERO};
      end else if (ce) begin
         if (req.cmd == CMD_LOAD_PTR) begin
            ptr_reg <= req.ptr;
         end else if (req.cmd == CMD_STEP_UP || req.cmd == CMD_STEP_DOWN) begin
            ptr_reg.column_index <= col_next;
         end
      end
   end

   // Skip: up skips on 15->0, down on 0->15, as in full variants
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         skip <= 1'b0;
      end else if (ce) begin
         skip <= (req.cmd == CMD_STEP_UP   && ptr_reg.column_index == COL_MAX) ||
                 (req.cmd == CMD_STEP_DOWN && ptr_reg.column_index == COL_ZERO);
      end
   end

   // Strobe nibble from whole index
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         strobe_out <= COL_ZERO;
      end else if (ce && req.cmd == CMD_STROBE) begin
         strobe_out <= ptr_reg.column_index;
      end
   end

   // Pointer copy to datapath
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ptr_out <= '{row_index: ROW_ZERO, column_index: COL_ZERO};
      end else if (ce) begin
         ptr_out <= ptr_reg;
      end
   end

   //------------------------------------------------------------
   // Return stack sequencer
   //------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP, ST_POP_WAIT} stk_state_t;

   stk_state_t       state_reg;
   logic [SP_W-1:0]  sp_reg [2];     // Next free slot per CPU
   logic             sel_reg;
   logic [1:0]       dig_reg;        // Digit within slot
   logic [PC_W-1:0]  pc_reg;         // Push data or pop accumulator
   logic [SP_W-1:0]  slot_reg;
   logic [DIG_W-1:0] ram_rdata;      // Registered RAM read digit

   // Wrap a slot number inside the area
   function automatic logic [SP_W-1:0] slot_inc(input logic [SP_W-1:0] s);
      slot_inc = (s == SP_W'(SLOTS - 1)) ? SP_ZERO : s + 4'h1;
   endfunction
   function automatic logic [SP_W-1:0] slot_dec(input logic [SP_W-1:0] s);
      slot_dec = (s == SP_ZERO) ? SP_W'(SLOTS - 1) : s - 4'h1;
   endfunction

   // Stack cell address, confined to the stack rows
   function automatic logic [ADDR_W-1:0] stack_cell(input logic sel,
                                                    input logic [SP_W-1:0] s,
                                                    input logic [1:0] d);
      logic [5:0] lin;
      lin = 6'(s) * 6'(SLOT_DIGS) + 6'(d);
      if (s >= SP_W'(SLOTS_ROW)) begin
         lin = 6'(s - SP_W'(SLOTS_ROW)) * 6'(SLOT_DIGS) + 6'(d);
         stack_cell = {stack_base(sel) + 5'h01, lin[COL_W-1:0]};
      end else begin
         stack_cell = {stack_base(sel), lin[COL_W-1:0]};
      end
   endfunction

   // Stack sequencer: three digit cycles per address
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_IDLE;
         sp_reg[0] <= SP_ZERO;
         sp_reg[1] <= SP_ZERO;
         sel_reg   <= 1'b0;
         dig_reg   <= 2'h0;
         pc_reg    <= PC_ZERO;
         slot_reg  <= SP_ZERO;
      end else if (ce) begin
         case (state_reg)
            ST_IDLE: begin
               dig_reg <= 2'h0;
               sel_reg <= (VARIANT == VAR_DUAL) ? req.cpu_sel : 1'b0;
               if (HAS_STK && req.cmd == CMD_CALL) begin
                  pc_reg    <= req.ret_addr;
                  slot_reg  <= sp_reg[(VARIANT == VAR_DUAL) ? req.cpu_sel : 1'b0];
                  state_reg <= ST_PUSH;
               end else if (HAS_STK && req.cmd == CMD_RET) begin
                  slot_reg  <= slot_dec(sp_reg[(VARIANT == VAR_DUAL) ? req.cpu_sel : 1'b0]);
                  pc_reg    <= PC_ZERO;
                  state_reg <= ST_POP;
               end
            end
            ST_PUSH: begin
               pc_reg  <= {pc_reg[PC_W-DIG_W-1:0], DIG_ZERO};
               dig_reg <= dig_reg + 2'h1;
               if (dig_reg == 2'(SLOT_DIGS - 1)) begin
                  // Overwrites oldest slot on overflow only
                  sp_reg[sel_reg] <= slot_inc(slot_reg);
                  state_reg       <= ST_IDLE;
               end
            end
            ST_POP: begin
               dig_reg <= dig_reg + 2'h1;
               if (dig_reg != 2'h0) begin
                  pc_reg <= {pc_reg[PC_W-DIG_W-1:0], ram_rdata};
               end
               if (dig_reg == 2'(SLOT_DIGS - 1)) begin
                  sp_reg[sel_reg] <= slot_reg;
                  state_reg       <= ST_POP_WAIT;
               end
            end
            ST_POP_WAIT: begin
               pc_reg    <= {pc_reg[PC_W-DIG_W-1:0], ram_rdata};
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // RAM port
   //------------------------------------------------------------
   logic [ADDR_W-1:0] ram_addr;
   logic              ram_we;
   logic [DIG_W-1:0]  ram_wdata;

   // Stack owns the port in ST_PUSH and ST_POP; else user pointer swap
   always_comb begin
      ram_addr  = cell_of(ptr_reg);
      ram_we    = 1'b0;
      ram_wdata = req.wdata;
      if (state_reg == ST_PUSH) begin
         ram_addr  = stack_cell(sel_reg, slot_reg, dig_reg);
         ram_we    = 1'b1;
         ram_wdata = pc_reg[PC_W-1 -: DIG_W];
      end else if (state_reg == ST_POP) begin
         ram_addr  = stack_cell(sel_reg, slot_reg, dig_reg);
      end else if (req.cmd == CMD_STEP_UP || req.cmd == CMD_STEP_DOWN) begin
         ram_we    = 1'b1;
      end
   end

   digit_ram u_ram (
      .clk   (clk),
      .ce    (ce),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // Old digit out and popped address
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata     <= DIG_ZERO;
         ret_out   <= PC_ZERO;
         ret_valid <= 1'b0;
      end else if (ce) begin
         rdata     <= ram_rdata;
         ret_valid <= (state_reg == ST_POP_WAIT);
         if (state_reg == ST_POP_WAIT) begin
            ret_out <= {pc_reg[PC_W-DIG_W-1:0], ram_rdata};
         end
      end
   end

endmodule

// File: shared/ram_addr_pkg.sv
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------
// What this block does
// - Reduced variant has four rows of eight digits; others sixteen digits per row
// - Column index stays a full four-bit field in every variant
// - Strobe nibble port loads from the whole four-bit column index
// - Eight-digit variants select the digit with the low three index bits only
// - Each eight-digit cell answers two index values differing in the top bit
// - Swap-step operations move the whole index; skip conditions unchanged
// - Stepping up counts the index through zero to fifteen
// - Return stack accesses stay inside the assigned stack area
// - Stack overflow loses only an old return address, never user data
// - Dual-CPU variant: first CPU stack row eight, second row nine
// - One group keeps stack in row fifteen, another in row eight
// - Largest variant keeps stack across rows thirty and thirty-one
// - Rows count from zero; stack row equals the row index value
package ram_addr_pkg;

   localparam int          ROW_W      = 5;           // Row index width (32 rows max)
   localparam int          COL_W      = 4;           // Column index width
   localparam int          DIG_W      = 4;           // One digit
   localparam int          PC_W       = 12;          // Return address width
   localparam int          ADDR_W     = ROW_W + COL_W;
   localparam int          DEPTH      = 512;
   localparam int          SLOT_DIGS  = 3;           // Digits per stacked address
   localparam int          SLOTS_ROW  = 5;           // Slots held by one 16-digit row
   localparam int          SP_W       = 4;
   localparam logic [ROW_W-1:0] STK_ROW_A   = 5'h08; // Single/first CPU
   localparam logic [ROW_W-1:0] STK_ROW_B   = 5'h09; // Second CPU
   localparam logic [ROW_W-1:0] STK_ROW_HI  = 5'h0F;
   localparam logic [ROW_W-1:0] STK_ROW_BIG = 5'h1E; // Spans 30 and 31
   localparam logic [ROW_W-1:0] SMALL_ROWS  = 5'h04;
   localparam logic [COL_W-1:0] COL_MAX     = 4'hF;
   localparam logic [COL_W-1:0] COL_ZERO    = 4'h0;
   localparam logic [ROW_W-1:0] ROW_ZERO    = 5'h00;
   localparam logic [SP_W-1:0]  SP_ZERO     = 4'h0;
   localparam logic [PC_W-1:0]  PC_ZERO     = 12'h000;
   localparam logic [DIG_W-1:0] DIG_ZERO    = 4'h0;

   // Variant selection
   typedef enum logic [2:0] {
      VAR_SMALL,     // 4 rows x 8 digits, no stack in RAM
      VAR_ROW8,      // Stack in row 8
      VAR_DUAL,      // Two CPUs, rows 8 and 9
      VAR_ROW15,     // Stack in row 15
      VAR_BIG        // Stack in rows 30 and 31
   } variant_t;

   // Datapath commands
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_LOAD_PTR,
      CMD_STEP_UP,
      CMD_STEP_DOWN,
      CMD_CALL,
      CMD_RET,
      CMD_STROBE
   } cmd_t;

   typedef struct packed {
      logic [ROW_W-1:0] row_index;
      logic [COL_W-1:0] column_index;
   } ram_ptr_t;

   typedef struct packed {
      cmd_t             cmd;
      logic             cpu_sel;      // Second CPU in dual variant
      ram_ptr_t         ptr;          // New pointer for load
      logic [DIG_W-1:0] wdata;        // Digit swapped into RAM
      logic [PC_W-1:0]  ret_addr;     // Address pushed on call
   } req_t;

endpackage

// File: verilog/digit_ram.sv
`timescale 1ns/100ps
module digit_ram
   import ram_addr_pkg::*;
(
   input  wire logic              clk,    // Core clock
   input  wire logic              ce,     // Clock enable
   input  wire logic              we,     // Write strobe
   input  wire logic [ADDR_W-1:0] addr,   // Cell address
   input  wire logic [DIG_W-1:0]  wdata,  // Write digit
   output logic      [DIG_W-1:0]  rdata   // Registered read digit
);

   logic [DIG_W-1:0] mem [DEPTH];

   // Write and registered read
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end

endmodule

// File: sim/data_ram_addressing_stack_properties.sv
`timescale 1ns/100ps
module data_ram_addressing_stack_properties
   import ram_addr_pkg::*;
#(
   parameter variant_t VARIANT = VAR_SMALL  // Device variant
)(
   input wire logic             clk,         // Core clock
   input wire logic             arst_n,      // Async reset
   input wire logic             ce,          // Clock enable
   input wire req_t             req,         // Datapath command
   input wire logic             skip,        // Step skip flag
   input wire logic [COL_W-1:0] strobe_out,  // Nibble strobe port
   input wire ram_ptr_t         ptr_out,     // Pointer copy
   input wire logic             ret_valid    // Pop done pulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // ----------------------------------
   // Command sequences
   // ----------------------------------
   sequence s_load;
      ce && req.cmd == CMD_LOAD_PTR;
   endsequence
   sequence s_up;
      ce && req.cmd == CMD_STEP_UP;
   endsequence
   sequence s_down;
      ce && req.cmd == CMD_STEP_DOWN;
   endsequence
   sequence s_ret;
      ce && req.cmd == CMD_RET && VARIANT != VAR_SMALL;
   endsequence

   // ----------------------------------
   // Checks
   // ----------------------------------
   a_load_full_col: assert property (
      s_load ##1 ce |=> ptr_out.column_index == $past(req.ptr.column_index, 2))
      else $error("pointer load lost column bits");
   a_up_whole_col: assert property (
      s_up ##1 ce |=> ptr_out.column_index == $past(ptr_out.column_index) + 4'h1)
      else $error("step up did not add one");
   a_down_whole_col: assert property (
      s_down ##1 ce |=> ptr_out.column_index == $past(ptr_out.column_index) - 4'h1)
      else $error("step down did not subtract one");
   a_skip_top_wrap: assert property (
      s_up |=> skip == (ptr_out.column_index == COL_MAX))
      else $error("step up skip wrong");
   a_skip_bottom_wrap: assert property (
      s_down |=> skip == (ptr_out.column_index == COL_ZERO))
      else $error("step down skip wrong");
   a_strobe_full_col: assert property (
      ce && req.cmd == CMD_STROBE |=> strobe_out == ptr_out.column_index)
      else $error("strobe port not full column");
   a_ret_on_time: assert property (
      s_ret ##1 ce [*4] |=> ret_valid)
      else $error("return address late");
   a_ret_one_cycle: assert property (
      ret_valid && ce |=> !ret_valid)
      else $error("return pulse too long");
   a_idle_frozen: assert property (
      !ce |=> $stable(ptr_out) && $stable(strobe_out))
      else $error("state moved without enable");
endmodule

// File: sim/cpu_seq_model.sv
`timescale 1ns/100ps
module cpu_seq_model
   import ram_addr_pkg::*;
(
   input  wire logic clk,  // Core clock
   output logic      ce,   // Clock enable to block
   output req_t      req   // Command to block
);
   // Quiet datapath at start
   initial begin
      ce  = 1'b1;
      req = '0;
   end

   // One command; stack commands keep the busy spacing
   task automatic send(input req_t r);
      int gap;
      gap = r.cmd == CMD_CALL ? 3 : r.cmd == CMD_RET ? 4 : 0;
      @(posedge clk);
      req <= r;
      ce  <= 1'b1;
      repeat (gap) begin
         @(posedge clk);
         req.cmd <= CMD_NONE;
      end
   endtask

   // Idle gap with a wandering enable
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         req.cmd <= CMD_NONE;
         ce      <= 1'($urandom);
      end
      @(posedge clk);
      ce <= 1'b1;
   endtask
endmodule

// File: sim/data_ram_addressing_stack_tb.sv
`timescale 1ns/100ps
module data_ram_addressing_stack_tb;
   import ram_addr_pkg::*;
   logic             clk = 1'b0;
   logic             arst_n = 1'b0;
   logic             ce;
   req_t             req;
   localparam variant_t VARS [5] = '{VAR_SMALL, VAR_ROW8, VAR_DUAL, VAR_ROW15, VAR_BIG};
   logic [DIG_W-1:0] rd [5];
   logic             skp [5];
   logic [COL_W-1:0] stb [5];
   ram_ptr_t         ptr [5];
   logic [PC_W-1:0]  rto [5];
   logic             rtv [5];
   logic [DIG_W-1:0] mem [5][512];
   logic [PC_W-1:0]  a [7];
   req_t             r;
   int               fail_count = 0;
   int               n_checks = 0;
   int               cyc = 0;
   int               t;

   // Every variant side by side, all fed the same commands
   for (genvar g = 0; g < 5; g++) begin : v
      data_ram_addressing_stack #(.VARIANT(VARS[g]))
         data_ram_addressing_stack_i (.clk(clk), .arst_n(arst_n), .ce(ce), .req(req),
         .rdata(rd[g]), .skip(skp[g]), .strobe_out(stb[g]), .ptr_out(ptr[g]),
         .ret_out(rto[g]), .ret_valid(rtv[g]));
   end
   cpu_seq_model cpu_seq_model_i (.clk(clk), .ce(ce), .req(req));

   // Clock and hang guard
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end

   // ----------------------------------
   // Helpers
   // ----------------------------------
   function automatic int idx(input int g, input ram_ptr_t p);
      return g ? {p.row_index, p.column_index} : {p.row_index[1:0], p.column_index[2:0]};
   endfunction

   // Expected stack cell of digit d of the k-th push, per variant
   function automatic int scell(input int g, input int k, input int d);
      int               s;
      logic [ROW_W-1:0] row;
      s = g == 4 ? k % (2 * SLOTS_ROW) : k % SLOTS_ROW;
      row = g == 2 ? STK_ROW_B : g == 3 ? STK_ROW_HI : g == 4 ? STK_ROW_BIG : STK_ROW_A;
      if (s >= SLOTS_ROW)
         row = row + 5'h01;
      return {row, 4'(SLOT_DIGS * (s % SLOTS_ROW) + d)};
   endfunction

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Load pointer, then swap-step n times, checking old digits
   task automatic walk(input ram_ptr_t p, input int n, input bit up);
      logic [DIG_W-1:0] e [$];
      logic [DIG_W-1:0] x;
      r = '0;
      r.cmd = CMD_LOAD_PTR;
      r.ptr = p;
      cpu_seq_model_i.send(r);
      for (int i = 0; i < n + 2; i++) begin
         r.cmd = i >= n ? CMD_NONE : up ? CMD_STEP_UP : CMD_STEP_DOWN;
         r.wdata = DIG_W'($urandom);
         for (int g = 0; g < 5 && i < n; g++) begin
            e.push_back(mem[g][idx(g, p)]);
            mem[g][idx(g, p)] = r.wdata;
         end
         p.column_index += up ? 4'h1 : 4'hF;
         cpu_seq_model_i.send(r);
         #1;
         for (int g = 0; g < 5 && i >= 2; g++) begin
            x = e.pop_front();
            if (!$isunknown(x)) chk(rd[g], x);
         end
      end
   endtask

   task automatic results();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------
   // Main sequence
   // ----------------------------------
   initial begin
      void'($urandom(49780));
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      walk(ram_ptr_t'{5'h00, 4'h0}, 16, 1'b1);
      walk(ram_ptr_t'{5'h00, 4'h3}, 18, 1'b0);
      for (int k = 0; k < 4; k++) begin
         walk(ram_ptr_t'{5'($urandom % 4), 4'($urandom)}, 1 + $urandom % 20, 1'($urandom));
         cpu_seq_model_i.idle(3 + $urandom % 4);
      end
      for (int c = 7; c < 16; c += 4) begin
         r = '0;
         r.cmd = CMD_LOAD_PTR;
         r.ptr.column_index = 4'(c);
         cpu_seq_model_i.send(r);
         r.cmd = CMD_STROBE;
         cpu_seq_model_i.send(r);
         r.cmd = CMD_NONE;
         cpu_seq_model_i.send(r);
         #1;
         for (int g = 0; g < 5; g++) chk(stb[g], 12'(c));
      end
      walk(ram_ptr_t'{5'h07, 4'h0}, 16, 1'b1);
      walk(ram_ptr_t'{5'h09, 4'h0}, 16, 1'b1);
      // Seven calls overflow the five-slot stacks of rows eight, nine and fifteen
      for (int k = 0; k < 7; k++) begin
         a[k] = PC_W'($urandom);
         r = '0;
         r.cmd = CMD_CALL;
         r.ret_addr = a[k];
         r.cpu_sel = 1'b1;
         cpu_seq_model_i.send(r);
         for (int g = 1; g < 5; g++)
            for (int d = 0; d < SLOT_DIGS; d++)
               mem[g][scell(g, k, d)] = a[k][11 - 4 * d -: 4];
      end
      for (int k = 6; k > 1; k--) begin
         r.cmd = CMD_RET;
         cpu_seq_model_i.send(r);
         t = 0;
         while (rtv[1] !== 1'b1 && t < 8) begin
            @(posedge clk);
            #1;
            t++;
         end
         for (int g = 1; g < 5; g++) chk(rto[g], a[k]);
      end
      walk(ram_ptr_t'{5'h07, 4'h0}, 16, 1'b1);
      walk(ram_ptr_t'{5'h09, 4'h0}, 16, 1'b1);
      walk(ram_ptr_t'{STK_ROW_A, 4'h0}, 15, 1'b1);
      walk(ram_ptr_t'{STK_ROW_HI, 4'h0}, 15, 1'b1);
      walk(ram_ptr_t'{STK_ROW_BIG, 4'h0}, 15, 1'b1);
      walk(ram_ptr_t'{STK_ROW_BIG + 5'h01, 4'h0}, 6, 1'b1);
      results();
   end
endmodule

bind data_ram_addressing_stack data_ram_addressing_stack_properties #(.VARIANT(VARIANT))
   props_i (.clk(clk), .arst_n(arst_n), .ce(ce), .req(req), .skip(skip),
   .strobe_out(strobe_out), .ptr_out(ptr_out), .ret_valid(ret_valid));
